// ---- hw/rvr_pkg.sv ----
package rvr_pkg;

  // register port request, one access per cycle
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rvr_req_type;

  typedef enum logic [1:0] {
    TM_IMMEDIATE = 2'b00,
    TM_ZERO_CROSS = 2'b01,
    TM_SOFT = 2'b10,
    TM_SOFT_ZERO = 2'b11
  } rvr_mode_type;

  // register offsets
  localparam logic [7:0] OFS_VOL_MIX = 8'h02;
  localparam logic [7:0] OFS_VOL_A = 8'h03;
  localparam logic [7:0] OFS_VOL_B = 8'h04;
  localparam logic [7:0] OFS_MODE3 = 8'h06;
  localparam logic [7:0] OFS_ID = 8'h07;

  // field positions
  localparam int MODE_LSB = 5;
  localparam int MUTE_BIT = 7;
  localparam int RAMP_UP_BIT = 3;
  localparam int RAMP_DN_BIT = 2;
  localparam logic [7:0] MODE3_MASK = 8'h1c;

  // values after reset
  localparam logic [7:0] RST_VOL_MIX = 8'h40;
  localparam logic [7:0] RST_VOL = 8'h00;
  localparam logic [7:0] RST_MODE3 = 8'h00;

  localparam logic [6:0] ATT_MAX = 7'h7f;

  // soft ramp step interval and internal reset hold
  localparam int CLK_PERIOD_NS = 5;
  localparam int SOFT_STEP_NS = 40;
  localparam int SOFT_STEP_CYCLES = SOFT_STEP_NS / CLK_PERIOD_NS;
  localparam int HOLD_NS = 20;
  localparam int HOLD_CYCLES = HOLD_NS / CLK_PERIOD_NS;

endpackage

// ---- hw/rvr_ramp.sv ----
`timescale 1ns/1ps
module rvr_ramp (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // control
  input wire logic [6:0] goal_i,
  input wire rvr_pkg::rvr_mode_type mode_i,
  input wire logic tick_i,
  input wire logic zc_i,
  input wire logic jump_i,
  // result
  output logic [6:0] att_o,
  output logic at_goal_o
);

  logic [6:0] att_r;
  logic [6:0] att_nxt;
  logic [6:0] step_val;
  logic step_ok;

  assign at_goal_o = (att_r == goal_i);
  assign step_val = (att_r < goal_i) ? att_r + 7'h01 : att_r - 7'h01;
  // soft with zero cross only steps on a tick that meets a crossing
  assign step_ok = (mode_i == rvr_pkg::TM_SOFT) ? tick_i : (tick_i & zc_i);

  always_comb begin
    att_nxt = att_r;
    if (jump_i) begin
      att_nxt = goal_i;
    end else if (!at_goal_o) begin
      case (mode_i)
        rvr_pkg::TM_IMMEDIATE: att_nxt = goal_i;
        rvr_pkg::TM_ZERO_CROSS: att_nxt = zc_i ? goal_i : att_r;
        default: att_nxt = step_ok ? step_val : att_r;
      endcase
    end
  end

  // comes out of reset fully attenuated
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      att_r <= rvr_pkg::ATT_MAX;
    end else begin
      att_r <= att_nxt;
    end
  end

  assign att_o = att_r;

endmodule // rvr_ramp

// ---- hw/rvr_top.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// RL1: ramp-up bit clear: jump from full attenuation to programmed volume at release.
// RL2: ramp-up bit set: ramp from full attenuation using transition mode.
// RL3: ramp-down bit clear: jump to full attenuation when the chip resets.
// RL4: ramp-down bit set: ramp to full attenuation before a known reset acts.
// RL5: read-only id register: part code high nibble, revision low nibble.
// RL6: two-bit mode: immediate, zero cross, soft ramp (default), soft plus zero cross.
// RL7: writes to the id register change nothing.
module rvr_top #(
  parameter logic [3:0] PART_CODE = 4'h5, // arbitrary value
  parameter logic [3:0] REV_CODE = 4'h1 // arbitrary value
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // register port
  input wire rvr_pkg::rvr_req_type req_i,
  output logic [7:0] rdata_o,
  // reset request and audio timing
  input wire logic soft_reset_req_i,
  input wire logic zero_cross_i,
  // volume path
  output logic [6:0] att_a_o,
  output logic [6:0] att_b_o,
  output logic internal_reset_o,
  output logic ramp_busy_o
);

  typedef enum logic [1:0] {ST_RUN, ST_RAMP_DN, ST_HOLD} rvr_state_type;

  rvr_state_type state_r;
  rvr_state_type state_nxt;
  logic [7:0] vol_mix_r;
  logic [7:0] vol_a_r;
  logic [7:0] vol_b_r;
  logic [7:0] mode3_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] tick_cnt_r;
  logic [7:0] hold_cnt_r;
  logic tick;
  logic ramp_up_en;
  logic ramp_dn_en;
  logic force_max;
  logic jump;
  logic hold_done;
  logic at_goal_a;
  logic at_goal_b;
  logic [6:0] goal_a;
  logic [6:0] goal_b;
  logic [7:0] id_val;
  rvr_pkg::rvr_mode_type mode;

  ////////////////////////////////////////////////////////////////////////
  // registers

  assign id_val = {PART_CODE, REV_CODE}; // RL5
  assign mode = rvr_pkg::rvr_mode_type'(vol_mix_r[rvr_pkg::MODE_LSB +: 2]); // RL6
  assign ramp_up_en = mode3_r[rvr_pkg::RAMP_UP_BIT];
  assign ramp_dn_en = mode3_r[rvr_pkg::RAMP_DN_BIT];

  // id offset has no write decode at all
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vol_mix_r <= rvr_pkg::RST_VOL_MIX;
      vol_a_r <= rvr_pkg::RST_VOL;
      vol_b_r <= rvr_pkg::RST_VOL;
      mode3_r <= rvr_pkg::RST_MODE3;
    end else if (req_i.wr) begin // RL7
      if (req_i.addr == rvr_pkg::OFS_VOL_MIX) begin
        vol_mix_r <= req_i.wdata;
      end else if (req_i.addr == rvr_pkg::OFS_VOL_A) begin
        vol_a_r <= req_i.wdata;
      end else if (req_i.addr == rvr_pkg::OFS_VOL_B) begin
        vol_b_r <= req_i.wdata;
      end else if (req_i.addr == rvr_pkg::OFS_MODE3) begin
        mode3_r <= req_i.wdata & rvr_pkg::MODE3_MASK;
      end
    end
  end

  always_comb begin
    rdata_nxt = 8'h00;
    if (req_i.addr == rvr_pkg::OFS_VOL_MIX) begin
      rdata_nxt = vol_mix_r;
    end else if (req_i.addr == rvr_pkg::OFS_VOL_A) begin
      rdata_nxt = vol_a_r;
    end else if (req_i.addr == rvr_pkg::OFS_VOL_B) begin
      rdata_nxt = vol_b_r;
    end else if (req_i.addr == rvr_pkg::OFS_MODE3) begin
      rdata_nxt = mode3_r;
    end else if (req_i.addr == rvr_pkg::OFS_ID) begin
      rdata_nxt = id_val; // RL5
    end
  end

  // read data holds until the next read
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_r <= 8'h00;
    end else if (req_i.rd) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // soft ramp step timer

  assign tick = (tick_cnt_r == 8'(rvr_pkg::SOFT_STEP_CYCLES - 1));

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_cnt_r <= 8'h00;
    end else begin
      // restart in hold so the first ramp-up step waits a full interval
      tick_cnt_r <= (tick || state_r == ST_HOLD) ? 8'h00 : tick_cnt_r + 8'h01; // RL2
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reset sequencing

  assign hold_done = (hold_cnt_r == 8'(rvr_pkg::HOLD_CYCLES - 1));

  always_comb begin
    state_nxt = state_r;
    jump = 1'b0;
    case (state_r)
      ST_RUN: begin
        if (soft_reset_req_i) begin
          if (ramp_dn_en) begin
            state_nxt = ST_RAMP_DN; // RL4
          end else begin
            state_nxt = ST_HOLD; // RL3
            jump = 1'b1;
          end
        end
      end
      ST_RAMP_DN: begin
        if (at_goal_a && at_goal_b) begin
          state_nxt = ST_HOLD; // RL4
        end
      end
      default: begin
        if (hold_done) begin
          state_nxt = ST_RUN;
          jump = !ramp_up_en; // RL1 RL2
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= ST_HOLD;
      hold_cnt_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      hold_cnt_r <= (state_r == ST_HOLD && !hold_done) ? hold_cnt_r + 8'h01 : 8'h00;
    end
  end

  function automatic logic [6:0] goal_of(input logic [7:0] vol, input logic hard_max);
    return (hard_max || vol[rvr_pkg::MUTE_BIT]) ? rvr_pkg::ATT_MAX : vol[6:0];
  endfunction

  // pin reset goes through the same hold so both releases behave alike
  // built from state_r, not state_nxt: avoids a loop through at_goal
  assign force_max = (state_r == ST_RUN) ? soft_reset_req_i
                   : ((state_r == ST_RAMP_DN) || !hold_done);
  assign goal_a = goal_of(vol_a_r, force_max);
  assign goal_b = goal_of(vol_b_r, force_max);

  rvr_ramp u_ramp_a (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .goal_i(goal_a),
    .mode_i(mode),
    .tick_i(tick),
    .zc_i(zero_cross_i),
    .jump_i(jump),
    .att_o(att_a_o),
    .at_goal_o(at_goal_a)
  );

  rvr_ramp u_ramp_b (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .goal_i(goal_b),
    .mode_i(mode),
    .tick_i(tick),
    .zc_i(zero_cross_i),
    .jump_i(jump),
    .att_o(att_b_o),
    .at_goal_o(at_goal_b)
  );

  assign internal_reset_o = (state_r == ST_HOLD);
  assign ramp_busy_o = (state_r != ST_HOLD) && !(at_goal_a && at_goal_b);

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_id_read_value: assert property ( // RL5
    req_i.rd && req_i.addr == rvr_pkg::OFS_ID |=> rdata_o == {PART_CODE, REV_CODE})
    else $error("id register read wrong value");

  a_id_write_inert: assert property ( // RL7
    req_i.wr && req_i.addr == rvr_pkg::OFS_ID
    |=> $stable(vol_mix_r) && $stable(vol_a_r) && $stable(vol_b_r) && $stable(mode3_r))
    else $error("write to id register changed state");

  a_release_jump_up: assert property ( // RL1
    state_r == ST_HOLD && hold_done && !ramp_up_en && !vol_a_r[rvr_pkg::MUTE_BIT]
    |=> att_a_o == $past(vol_a_r[6:0]))
    else $error("volume did not jump at release");

  a_release_ramp_up: assert property ( // RL2
    state_r == ST_HOLD && hold_done && ramp_up_en && mode == rvr_pkg::TM_SOFT
    |=> att_a_o == rvr_pkg::ATT_MAX ##1 att_a_o == rvr_pkg::ATT_MAX)
    else $error("ramp up did not start from full attenuation");

  a_enter_jump_down: assert property ( // RL3
    state_r == ST_RUN && soft_reset_req_i && !ramp_dn_en
    |=> internal_reset_o && att_a_o == rvr_pkg::ATT_MAX && att_b_o == rvr_pkg::ATT_MAX)
    else $error("volume did not jump down on reset");

  a_ramp_before_reset: assert property ( // RL4
    state_r == ST_RUN && soft_reset_req_i && ramp_dn_en |=> !internal_reset_o)
    else $error("reset acted before ramp down");

  a_hold_max_att: assert property ( // RL4
    internal_reset_o |-> att_a_o == rvr_pkg::ATT_MAX && att_b_o == rvr_pkg::ATT_MAX)
    else $error("reset held without full attenuation");

  a_soft_single_step: assert property ( // RL6
    state_r != ST_HOLD && $past(state_r) != ST_HOLD && mode == rvr_pkg::TM_SOFT
    && $past(mode) == rvr_pkg::TM_SOFT && att_a_o != $past(att_a_o)
    |-> (att_a_o - $past(att_a_o) == 7'h01) || ($past(att_a_o) - att_a_o == 7'h01))
    else $error("soft ramp moved more than one step");

  a_soft_zero_gate: assert property ( // RL6
    mode == rvr_pkg::TM_SOFT_ZERO && !zero_cross_i && !jump |=> $stable(att_a_o))
    else $error("soft ramp with zero cross stepped without a crossing");

  a_hold_length: assert property ( // RL3
    $rose(internal_reset_o) |-> internal_reset_o [*4] ##1 !internal_reset_o)
    else $error("internal reset hold length wrong");

  c_ramp_down: cover property (state_r == ST_RAMP_DN ##1 state_r == ST_HOLD);
  c_ramp_up: cover property (state_r == ST_HOLD && hold_done && ramp_up_en);
  c_id_read: cover property (req_i.rd && req_i.addr == rvr_pkg::OFS_ID);

endmodule // rvr_top

// ---- test/tb_rvr_top.sv ----
`timescale 1ns/1ps
module tb_rvr_top;
  typedef struct {int sel; logic [7:0] exp; logic [7:0] val;} rvr_note_type;
  localparam logic [7:0] ID_EXP = 8'ha3;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  rvr_pkg::rvr_req_type req = '0;
  logic soft_req = 1'b0;
  logic zc = 1'b1;
  logic [7:0] rdata;
  logic [6:0] att_a;
  logic [6:0] att_b;
  logic irst;
  logic busy;
  int miscompares = 0;
  int compares = 0;
  int seed = 46379;
  int n;
  rvr_note_type notes[$];
  event note_ev;

  always #2.5 clk_i = ~clk_i;

  rvr_top #(.PART_CODE(4'ha), .REV_CODE(4'h3)) i_rvr_top (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req), .rdata_o(rdata),
    .soft_reset_req_i(soft_req), .zero_cross_i(zc), .att_a_o(att_a), .att_b_o(att_b),
    .internal_reset_o(irst), .ramp_busy_o(busy));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // monitor drains every note at the moment it is posted, outputs already settled
  always @(note_ev) begin
    rvr_note_type e;
    while (notes.size() > 0) begin
      e = notes.pop_front();
      case (e.sel)
        0: check("rdata", rdata, e.exp);
        1: check("att_a", {1'b0, att_a}, e.exp);
        2: check("att_b", {1'b0, att_b}, e.exp);
        3: check("internal_reset", {7'h00, irst}, e.exp);
        default: check("timing", e.val, e.exp);
      endcase
    end
  end

  task automatic note(input int sel, input logic [7:0] exp, input logic [7:0] val = 8'h00);
    notes.push_back('{sel, exp, val});
    ->note_ev;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // one idle negedge after each strobe so req is never assigned twice in a step
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(negedge clk_i);
    req = '0;
    @(negedge clk_i);
  endtask

  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(negedge clk_i);
    req = '0;
    note(0, exp);
    @(negedge clk_i);
  endtask

  function automatic logic cond(input int c);
    case (c)
      0: return irst === 1'b1;
      1: return irst === 1'b0;
      default: return busy === 1'b0;
    endcase
  endfunction

  task automatic wait_until(input int c, output int cnt);
    cnt = 0;
    while (!cond(c) && cnt < 400) begin
      @(negedge clk_i);
      cnt++;
    end
    if (cnt >= 400) begin
      check("wait_done", 8'h00, 8'h01);
    end
  endtask

  // full reset round trip; ramps must take more than 8 cycles, jumps at most 8
  task automatic cycle(input logic [1:0] m, input logic [7:0] ctl);
    logic [31:0] r;
    logic [7:0] va;
    logic [7:0] vb;
    int k;
    r = $random(seed);
    va = {1'b0, 4'he, r[2:0]};
    vb = {1'b0, 4'he, r[5:3]};
    wr(rvr_pkg::OFS_VOL_MIX, {1'b0, m, 5'h00});
    wr(rvr_pkg::OFS_MODE3, ctl);
    wr(rvr_pkg::OFS_VOL_A, va);
    wr(rvr_pkg::OFS_VOL_B, vb);
    wait_until(2, k);
    // zero cross and soft plus zero cross both must wait for a crossing
    if (m[0]) zc = 1'b0;
    soft_req = 1'b1;
    @(negedge clk_i);
    soft_req = 1'b0;
    if (m[0]) begin
      repeat (20) @(negedge clk_i);
      note(3, 8'h00);
      note(1, va);
      zc = 1'b1;
    end
    wait_until(0, k);
    note(9, {7'h00, m[1] & ctl[2]}, {7'h00, k > 8});
    note(1, 8'h7f);
    note(2, 8'h7f);
    wait_until(1, k);
    note(9, 8'h04, k[7:0]);
    @(negedge clk_i);
    wait_until(2, k);
    note(9, {7'h00, m[1] & ctl[3]}, {7'h00, k > 8});
    note(1, va);
    note(2, vb);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    repeat (2) @(negedge clk_i);
    note(1, 8'h7f);
    note(3, 8'h01);
    note(0, 8'h00);
    repeat (2) @(negedge clk_i);
    rst_b_i = 1'b1;
    wait_until(1, n);
    @(negedge clk_i);
    note(1, 8'h00);
    rd(rvr_pkg::OFS_ID, ID_EXP);
    r = $random(seed);
    wr(rvr_pkg::OFS_ID, r[7:0]);
    rd(rvr_pkg::OFS_ID, ID_EXP);
    rd(rvr_pkg::OFS_VOL_MIX, rvr_pkg::RST_VOL_MIX);
    rd(rvr_pkg::OFS_MODE3, rvr_pkg::RST_MODE3);
    rd(8'h05, 8'h00);
    wr(rvr_pkg::OFS_MODE3, 8'hff);
    rd(rvr_pkg::OFS_MODE3, rvr_pkg::MODE3_MASK);
    for (int m = 0; m < 4; m++) begin
      cycle(m[1:0], 8'h0c);
    end
    cycle(rvr_pkg::TM_SOFT, 8'h00);
    @(negedge clk_i);
    finish_test;
  end

  // whole run is well under a thousand cycles; this limit only catches a hang
  initial begin
    #200000;
    miscompares++;
    finish_test;
  end
endmodule // tb_rvr_top
